/* File: common/epc_pkg.sv */
package epc_pkg;
   // bus and storage widths
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int ARRAY_BYTES = 512;
   localparam int INDEX_W = 9;
   localparam int NUM_BLOCKS = 4;
   localparam int BLOCK_W = 2;
   // address map
   localparam logic [ADDR_W-1:0] ARRAY_BASE = 16'h0800;
   localparam logic [ADDR_W-1:0] ARRAY_LAST = 16'h09FF;
   localparam logic [ADDR_W-1:0] NVCFG_ADDR = 16'hFE1C;
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'hFE1D;
   localparam logic [ADDR_W-1:0] ACR_ADDR = 16'hFE1F;
   // cell and register values
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   localparam logic [DATA_W-1:0] NVCFG_DELIVERED = 8'h10;
   localparam logic [DATA_W-1:0] ACR_RESET = 8'h00;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
   // control register bit positions
   localparam int CTRL_BUSCLK_BIT = 7;
   localparam int CTRL_OFF_BIT = 5;
   localparam int CTRL_RAS1_BIT = 4;
   localparam int CTRL_RAS0_BIT = 3;
   localparam int CTRL_LAT_BIT = 2;
   localparam int CTRL_PGM_BIT = 0;
   // protect bits sit in the low nibble of the config bytes
   localparam int ACR_PROT_LSB = 0;

   // operation picked by the two erase-select bits
   typedef enum logic [1:0] {
      EPC_BYTE_PROGRAM = 2'h0,
      EPC_BYTE_ERASE = 2'h1,
      EPC_BLOCK_ERASE = 2'h2,
      EPC_BULK_ERASE = 2'h3
   } epc_mode_type;

   // one cycle of the cpu register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } epc_bus_req_type;

   // high-voltage operation handed to the cell array
   typedef struct packed {
      logic apply;
      epc_mode_type mode;
      logic nv_sel;
      logic [INDEX_W-1:0] index;
      logic [DATA_W-1:0] data;
   } epc_op_type;

   // true for an address inside the cell array
   function automatic logic epc_is_array(input logic [ADDR_W-1:0] addr);
      return (addr >= ARRAY_BASE) && (addr <= ARRAY_LAST);
   endfunction : epc_is_array

   // 128-byte block number of an array index
   function automatic logic [BLOCK_W-1:0] epc_block_of(input logic [INDEX_W-1:0] idx);
      return idx[INDEX_W-1 -: BLOCK_W];
   endfunction : epc_block_of
endpackage : epc_pkg

/* File: hw/epc_cells.sv */
`timescale 1ns/1ns
module epc_cells (
   input wire logic clk,
   input epc_pkg::epc_op_type op,
   input wire logic [epc_pkg::INDEX_W-1:0] rd_index,
   output logic [epc_pkg::DATA_W-1:0] rd_data,
   output logic [epc_pkg::DATA_W-1:0] nv_data
);
   import epc_pkg::*;

   // nonvolatile cells, not touched by reset; factory state all ones
   logic [DATA_W-1:0] mem [0:ARRAY_BYTES-1] = '{default: ERASED_BYTE};
   // config byte delivered unprotected, bit four set
   logic [DATA_W-1:0] nv_cell = NVCFG_DELIVERED;

   // asynchronous read ports
   assign rd_data = mem[rd_index];
   assign nv_data = nv_cell;

   // config byte only reacts to byte operations
   always_ff @(posedge clk) begin
      if (op.apply && op.nv_sel) begin
         unique case (op.mode)
            EPC_BYTE_PROGRAM: nv_cell <= nv_cell & op.data;
            EPC_BYTE_ERASE: nv_cell <= ERASED_BYTE;
            EPC_BLOCK_ERASE: nv_cell <= nv_cell;
            EPC_BULK_ERASE: nv_cell <= nv_cell;
         endcase
      end
   end

   // array cells: program pulls bits to zero, erase restores ones
   always_ff @(posedge clk) begin
      if (op.apply && !op.nv_sel) begin
         for (int i = 0; i < ARRAY_BYTES; i++) begin
            unique case (op.mode)
               EPC_BYTE_PROGRAM: begin
                  if (INDEX_W'(i) == op.index) begin
                     mem[i] <= mem[i] & op.data;
                  end
               end
               EPC_BYTE_ERASE: begin
                  if (INDEX_W'(i) == op.index) begin
                     mem[i] <= ERASED_BYTE;
                  end
               end
               EPC_BLOCK_ERASE: begin
                  if (epc_block_of(INDEX_W'(i)) == epc_block_of(op.index)) begin
                     mem[i] <= ERASED_BYTE;
                  end
               end
               EPC_BULK_ERASE: mem[i] <= ERASED_BYTE;
            endcase
         end
      end
   end
endmodule : epc_cells

/* File: hw/epc_eeprom_ctrl.sv */
`timescale 1ns/1ns
// Functional notes
// - program and erase from on-chip pump only
// - erased reads one, program writes zero
// - delivered all ones, config bit four set
// - only unprotected array bytes and config byte
// - erase bits zero program, otherwise erase
// - latch captures valid array writes, last wins
// - latched reads of array return captured data
// - control writes ignored until capture while latched
// - no program enable without latch and capture
// - program enable switches pump and high voltage
// - clearing enable and latch together clears enable
// - mode codes; protected target gets nothing
// - byte, block, bulk erase extents
// - block and bulk erase spare config byte
// - erase bits frozen while program enable set
// - protected block refused, bulk needs none protected
// - config copied on reset and config read
// - four 128-byte blocks, one protect bit each
module epc_eeprom_ctrl (
   input wire logic clk,
   input wire logic rst,
   input epc_pkg::epc_bus_req_type bus_req,
   output logic [epc_pkg::DATA_W-1:0] bus_rdata,
   output logic pump_on,
   output logic [epc_pkg::DATA_W-1:0] array_config
);
   import epc_pkg::*;

   // control register fields
   logic bus_clk_sel_reg; // pump clock choice, stored only
   logic power_down_reg; // array power-down, stored only
   epc_mode_type erase_mode_reg; // erase-select pair
   epc_mode_type erase_mode_next;
   logic bus_latch_mode_reg; // address/data capture mode
   logic bus_latch_mode_next;
   logic hv_program_enable_reg; // program/erase enable
   logic hv_program_enable_next;
   // captured target of the latched write
   logic captured_reg;
   logic captured_next;
   logic cap_nv_reg;
   logic [INDEX_W-1:0] cap_index_reg;
   logic [DATA_W-1:0] cap_data_reg;
   // volatile copy of the config byte
   logic [DATA_W-1:0] array_config_reg;
   logic boot_load_reg;
   // outputs
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic pump_reg;
   // decode
   logic wr_array, wr_nv, wr_ctrl, rd_array, rd_nv;
   logic capture_now;
   logic ctrl_write_ok;
   logic target_allowed;
   logic [NUM_BLOCKS-1:0] protect_bits;
   // cell array ports
   epc_op_type op;
   logic [DATA_W-1:0] cell_rd_data;
   logic [DATA_W-1:0] nv_data;

   // may the latched target receive high voltage in this mode
   function automatic logic target_ok(input epc_mode_type mode, input logic nv,
                                      input logic [INDEX_W-1:0] idx, input logic [NUM_BLOCKS-1:0] prot);
      logic ok;
      ok = 1'b0;
      unique case (mode)
         EPC_BYTE_PROGRAM: ok = nv || !prot[epc_block_of(idx)];
         EPC_BYTE_ERASE: ok = nv || !prot[epc_block_of(idx)];
         EPC_BLOCK_ERASE: ok = !nv && !prot[epc_block_of(idx)];
         EPC_BULK_ERASE: ok = !nv && (prot == '0);
      endcase
      return ok;
   endfunction : target_ok

   // address decode of the current strobe
   assign wr_array = bus_req.wr && epc_is_array(bus_req.addr);
   assign wr_nv = bus_req.wr && (bus_req.addr == NVCFG_ADDR);
   assign wr_ctrl = bus_req.wr && (bus_req.addr == CTRL_ADDR);
   assign rd_array = bus_req.rd && epc_is_array(bus_req.addr);
   assign rd_nv = bus_req.rd && (bus_req.addr == NVCFG_ADDR);
   // target frozen while high voltage may be on
   assign capture_now = bus_latch_mode_reg && !hv_program_enable_reg && (wr_array || wr_nv);
   // latched but nothing captured yet locks the control register
   assign ctrl_write_ok = wr_ctrl && !(bus_latch_mode_reg && !captured_reg);
   assign protect_bits = array_config_reg[ACR_PROT_LSB +: NUM_BLOCKS];
   assign target_allowed = target_ok(erase_mode_reg, cap_nv_reg, cap_index_reg, protect_bits);

   // next control field values
   always_comb begin
      erase_mode_next = erase_mode_reg;
      bus_latch_mode_next = bus_latch_mode_reg;
      hv_program_enable_next = hv_program_enable_reg;
      if (ctrl_write_ok) begin
         // mode pair ignored while enable is set
         if (!hv_program_enable_reg) begin
            erase_mode_next = epc_mode_type'(bus_req.wdata[CTRL_RAS1_BIT:CTRL_RAS0_BIT]);
         end
         // enable only after a captured latched write
         hv_program_enable_next = bus_req.wdata[CTRL_PGM_BIT] && bus_latch_mode_reg && captured_reg;
         // latch stays while enable was set, lets voltage decay
         if (hv_program_enable_reg) begin
            bus_latch_mode_next = 1'b1;
         end else begin
            bus_latch_mode_next = bus_req.wdata[CTRL_LAT_BIT];
         end
      end
   end

   // capture flag drops with the latch, set wins on capture
   always_comb begin
      captured_next = captured_reg && bus_latch_mode_next;
      if (capture_now) begin
         captured_next = 1'b1;
      end
   end

   // control register state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         erase_mode_reg <= EPC_BYTE_PROGRAM;
         bus_latch_mode_reg <= 1'b0;
         hv_program_enable_reg <= 1'b0;
         bus_clk_sel_reg <= 1'b0;
         power_down_reg <= 1'b0;
      end else begin
         erase_mode_reg <= erase_mode_next;
         bus_latch_mode_reg <= bus_latch_mode_next;
         hv_program_enable_reg <= hv_program_enable_next;
         if (ctrl_write_ok) begin
            bus_clk_sel_reg <= bus_req.wdata[CTRL_BUSCLK_BIT];
            power_down_reg <= bus_req.wdata[CTRL_OFF_BIT];
         end
      end
   end

   // captured address and data, each new valid write replaces the last
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         captured_reg <= 1'b0;
         cap_nv_reg <= 1'b0;
         cap_index_reg <= '0;
         cap_data_reg <= ZERO_BYTE;
      end else begin
         captured_reg <= captured_next;
         if (capture_now) begin
            cap_nv_reg <= wr_nv;
            cap_index_reg <= bus_req.addr[INDEX_W-1:0];
            cap_data_reg <= bus_req.wdata;
         end
      end
   end

   // pump and high voltage follow the enable, gated by protection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pump_reg <= 1'b0;
      end else begin
         // on until software clears the enable, no timer here
         pump_reg <= hv_program_enable_reg && captured_reg && target_allowed;
      end
   end

   // config copy loaded once after reset and on every config read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boot_load_reg <= 1'b1;
         array_config_reg <= ACR_RESET;
      end else begin
         boot_load_reg <= 1'b0;
         if (boot_load_reg || rd_nv) begin
            array_config_reg <= nv_data;
         end
      end
   end

   // read data for the cycle after a read strobe
   always_comb begin
      rdata_next = ZERO_BYTE;
      if (bus_req.rd) begin
         if (rd_array) begin
            // latched array reads show the captured byte
            if (bus_latch_mode_reg && captured_reg && !cap_nv_reg) begin
               rdata_next = cap_data_reg;
            end else begin
               rdata_next = cell_rd_data;
            end
         end else if (rd_nv) begin
            rdata_next = nv_data;
         end else if (bus_req.addr == CTRL_ADDR) begin
            rdata_next = {bus_clk_sel_reg, 1'b0, power_down_reg, erase_mode_reg,
                          bus_latch_mode_reg, 1'b0, hv_program_enable_reg};
         end else if (bus_req.addr == ACR_ADDR) begin
            rdata_next = array_config_reg;
         end
      end
   end

   // read data register, zero outside the answer cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= ZERO_BYTE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // operation presented to the cells while voltage is applied
   assign op.apply = pump_reg;
   assign op.mode = erase_mode_reg;
   assign op.nv_sel = cap_nv_reg;
   assign op.index = cap_index_reg;
   assign op.data = cap_data_reg;

   // cell array
   epc_cells u_cells (
      .clk(clk),
      .op(op),
      .rd_index(bus_req.addr[INDEX_W-1:0]),
      .rd_data(cell_rd_data),
      .nv_data(nv_data)
   );

   // outputs straight from flops
   assign bus_rdata = rdata_reg;
   assign pump_on = pump_reg;
   assign array_config = array_config_reg;

   // pump only ever follows a latched, captured enable
   AST_PUMP_NEEDS_CAPTURE: assert property (@(posedge clk) disable iff (rst)
      pump_reg |-> $past(hv_program_enable_reg) && $past(bus_latch_mode_reg) && $past(captured_reg))
      else $error("pump on without latched capture");

   // clearing enable drops the pump on the following edge
   AST_PUMP_FOLLOWS_ENABLE: assert property (@(posedge clk) disable iff (rst)
      $fell(hv_program_enable_reg) |=> !pump_reg)
      else $error("pump still on after enable cleared");

   // clearing both bits at once keeps the latch
   AST_CLEAR_BOTH_KEEPS_LATCH: assert property (@(posedge clk) disable iff (rst)
      (ctrl_write_ok && hv_program_enable_reg && !bus_req.wdata[CTRL_LAT_BIT] && !bus_req.wdata[CTRL_PGM_BIT])
      |=> bus_latch_mode_reg && !hv_program_enable_reg)
      else $error("latch cleared together with enable");

   // erase mode stable while enable set
   AST_MODE_FROZEN: assert property (@(posedge clk) disable iff (rst)
      hv_program_enable_reg |=> $stable(erase_mode_reg))
      else $error("erase mode changed under enable");

   // locked control register ignores writes
   AST_CTRL_LOCKED: assert property (@(posedge clk) disable iff (rst)
      (wr_ctrl && bus_latch_mode_reg && !captured_reg)
      |=> $stable(erase_mode_reg) && bus_latch_mode_reg && !hv_program_enable_reg)
      else $error("control write taken before capture");

   // latched array read returns captured data next cycle
   AST_LATCHED_READ: assert property (@(posedge clk) disable iff (rst)
      (rd_array && bus_latch_mode_reg && captured_reg && !cap_nv_reg) |=> bus_rdata == $past(cap_data_reg))
      else $error("latched read did not return captured data");

   // capture replaces address and data
   AST_CAPTURE: assert property (@(posedge clk) disable iff (rst)
      capture_now |=> captured_reg && cap_data_reg == $past(bus_req.wdata)
      && cap_index_reg == $past(bus_req.addr[INDEX_W-1:0]))
      else $error("valid latched write not captured");

   // config read reloads the volatile copy
   AST_ACR_RELOAD: assert property (@(posedge clk) disable iff (rst)
      rd_nv |=> array_config_reg == $past(nv_data))
      else $error("config copy not reloaded");

   // bulk erase refused while any block is protected
   AST_BULK_PROTECTED: assert property (@(posedge clk) disable iff (rst)
      (erase_mode_reg == EPC_BULK_ERASE && protect_bits != '0) |=> !pump_reg)
      else $error("bulk erase ran with protection set");

   // config byte never gets block or bulk erase voltage
   AST_NV_BYTE_ONLY: assert property (@(posedge clk) disable iff (rst)
      (cap_nv_reg && erase_mode_reg[1]) |=> !pump_reg)
      else $error("config byte hit by block or bulk erase");

   // read data stands only in the answer cycle
   AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
      !bus_req.rd |=> bus_rdata == ZERO_BYTE)
      else $error("read data outside answer cycle");

   // plain control write never raises the enable
   AST_ENABLE_NEEDS_LATCH: assert property (@(posedge clk) disable iff (rst)
      (wr_ctrl && !bus_latch_mode_reg) |=> !hv_program_enable_reg)
      else $error("enable set without latch");

   // protected block never sees high voltage
   AST_PROTECTED_BLOCK: assert property (@(posedge clk) disable iff (rst)
      (!cap_nv_reg && protect_bits[epc_block_of(cap_index_reg)]) |=> !pump_reg)
      else $error("high voltage on protected block");

   // copy taken from the config byte on the first edge out of reset
   AST_BOOT_LOAD: assert property (@(posedge clk) disable iff (rst)
      $fell(boot_load_reg) |-> array_config_reg == $past(nv_data))
      else $error("config copy not loaded after reset");
endmodule : epc_eeprom_ctrl

/* File: tb/epc_cpu_model.sv */
`timescale 1ns/1ns
// cpu-side master: drives the register port and runs the latched sequences
module epc_cpu_model (
   input wire logic clk,
   output epc_pkg::epc_bus_req_type bus_req,
   input wire logic [epc_pkg::DATA_W-1:0] bus_rdata,
   input wire logic pump_on
);
   import epc_pkg::*;
   localparam int PGM_WAIT = 6; // program or erase hold, timed by software
   localparam int FALL_WAIT = 3; // high-voltage decay hold
   logic pump_seen; // pump level sampled in mid-operation
   logic [DATA_W-1:0] ctrl_seen; // control byte read back after the clearing write

   // bus idle from time zero
   initial begin
      bus_req = '0;
      pump_seen = 1'b0;
      ctrl_seen = ZERO_BYTE;
   end

   // one write cycle, then idle
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      bus_req <= '0;
   endtask : wr

   // one read cycle; data taken in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ZERO_BYTE};
      @(posedge clk);
      bus_req <= '0;
      #1;
      d = bus_rdata;
   endtask : rd

   // full latched operation; waits counted here since the block has no timer
   task automatic op(input epc_mode_type m, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      wr(CTRL_ADDR, {3'b000, m, 3'b100});
      wr(a, d);
      wr(CTRL_ADDR, {3'b000, m, 3'b101});
      repeat (PGM_WAIT) @(posedge clk);
      #1;
      pump_seen = pump_on;
      wr(CTRL_ADDR, ZERO_BYTE);
      rd(CTRL_ADDR, ctrl_seen);
      repeat (FALL_WAIT) @(posedge clk);
      wr(CTRL_ADDR, ZERO_BYTE);
   endtask : op

   // erase the byte first, then program it
   task automatic prog(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      op(EPC_BYTE_ERASE, a, d);
      op(EPC_BYTE_PROGRAM, a, d);
   endtask : prog
endmodule : epc_cpu_model

/* File: tb/epc_eeprom_ctrl_bench.sv */
`timescale 1ns/1ns
// compare and count
`define check(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         err_total++; \
         $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module epc_eeprom_ctrl_bench;
   import epc_pkg::*;
   localparam int LIMIT = 4000; // cycle ceiling, well above the run length
   logic clk; // 20 MHz system clock
   logic rst; // async reset, active high
   epc_bus_req_type bus_req; // register port request
   logic [DATA_W-1:0] bus_rdata; // register port read data
   logic pump_on; // high voltage applied
   logic [DATA_W-1:0] array_config; // volatile config copy
   int err_total = 0; // mismatches
   int samples_checked = 0; // comparisons
   int cycles = 0; // elapsed clock cycles
   logic [DATA_W-1:0] got; // last read value

   epc_eeprom_ctrl DUT (
      .clk(clk),
      .rst(rst),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .pump_on(pump_on),
      .array_config(array_config)
   );

   epc_cpu_model cpu (
      .clk(clk),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .pump_on(pump_on)
   );

   // clock generation
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // one line per finished test
   task automatic done(input string name);
      $display("test %s ended", name);
   endtask : done

   // read and compare
   task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      cpu.rd(a, got);
      `check(got, exp)
   endtask : chk_rd

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_total++;
         results();
      end
   end

   // main sequence
   initial begin
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      // delivered state and reset load
      `check(array_config, NVCFG_DELIVERED)
      chk_rd(NVCFG_ADDR, NVCFG_DELIVERED);
      chk_rd(ARRAY_BASE, ERASED_BYTE);
      chk_rd(ARRAY_LAST, ERASED_BYTE);
      chk_rd(16'hFE00, ZERO_BYTE);
      chk_rd(ACR_ADDR, NVCFG_DELIVERED);
      done("reset");
      // enable refused after a plain write, control locked until capture
      cpu.wr(16'hFE00, 8'h5A);
      cpu.wr(CTRL_ADDR, 8'h01);
      chk_rd(CTRL_ADDR, ZERO_BYTE);
      cpu.wr(CTRL_ADDR, 8'h04);
      cpu.wr(16'hFE00, 8'h77);
      cpu.wr(CTRL_ADDR, 8'h05);
      chk_rd(CTRL_ADDR, 8'h04);
      cpu.wr(16'h0812, 8'h33);
      cpu.wr(16'h0813, 8'h5A);
      chk_rd(16'h0900, 8'h5A);
      `check(pump_on, 1'b0)
      cpu.wr(CTRL_ADDR, ZERO_BYTE);
      chk_rd(16'h0813, ERASED_BYTE);
      done("interlock");
      // byte program
      cpu.prog(16'h0812, 8'hA5);
      `check(cpu.pump_seen, 1'b1)
      `check(cpu.ctrl_seen, 8'h04)
      chk_rd(16'h0812, 8'hA5);
      chk_rd(16'h0811, ERASED_BYTE);
      done("program");
      // byte, block and bulk erase extents
      cpu.prog(16'h0890, ZERO_BYTE);
      cpu.prog(16'h0900, 8'h3C);
      cpu.op(EPC_BYTE_ERASE, 16'h0812, ZERO_BYTE);
      `check(cpu.ctrl_seen, 8'h0C)
      chk_rd(16'h0812, ERASED_BYTE);
      cpu.op(EPC_BLOCK_ERASE, 16'h08FF, ZERO_BYTE);
      chk_rd(16'h0890, ERASED_BYTE);
      chk_rd(16'h0900, 8'h3C);
      cpu.op(EPC_BULK_ERASE, 16'h09FF, ZERO_BYTE);
      chk_rd(16'h0900, ERASED_BYTE);
      cpu.op(EPC_BLOCK_ERASE, NVCFG_ADDR, ZERO_BYTE);
      `check(cpu.pump_seen, 1'b0)
      `check(cpu.ctrl_seen, 8'h14)
      chk_rd(NVCFG_ADDR, NVCFG_DELIVERED);
      done("erase");
      // erase select frozen while enabled
      cpu.wr(CTRL_ADDR, 8'h04);
      cpu.wr(16'h0815, ZERO_BYTE);
      cpu.wr(CTRL_ADDR, 8'h05);
      cpu.wr(CTRL_ADDR, 8'h1D);
      chk_rd(CTRL_ADDR, 8'h05);
      cpu.wr(CTRL_ADDR, ZERO_BYTE);
      repeat (3) @(posedge clk);
      cpu.wr(CTRL_ADDR, ZERO_BYTE);
      chk_rd(16'h0815, ZERO_BYTE);
      done("frozen");
      // block 1 protected through the config byte
      cpu.prog(NVCFG_ADDR, 8'h12);
      `check(array_config, NVCFG_DELIVERED)
      chk_rd(NVCFG_ADDR, 8'h12);
      `check(array_config, 8'h12)
      cpu.prog(16'h08A0, ZERO_BYTE);
      `check(cpu.pump_seen, 1'b0)
      chk_rd(16'h08A0, ERASED_BYTE);
      cpu.prog(16'h0820, ZERO_BYTE);
      cpu.op(EPC_BULK_ERASE, 16'h0820, ZERO_BYTE);
      chk_rd(16'h0820, ZERO_BYTE);
      // second reset reloads the copy
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `check(array_config, 8'h12)
      done("protect");
      results();
   end
endmodule : epc_eeprom_ctrl_bench
